// ---- aets_unit.sv ----
// One converter unit: trigger edge detect, sequencing and result store
`timescale 1ns/1ns
module aets_unit #(
	parameter int CHANS = 6,
	parameter int CW    = 3
) (
	input  wire logic                      core_clk_in,
	input  wire logic                      arst_n_in,
	input  wire logic                      trig_in,
	input  wire logic [1:0]                edge_sel_in,
	input  wire logic                      conv_enable_in,
	input  wire logic                      scan_mode_in,
	input  wire logic [CW-1:0]             chan_first_in,
	input  wire logic [CW-1:0]             chan_last_in,
	input  wire logic [2:0]                conv_time_sel_in,
	input  wire logic                      suspend_in,
	input  wire logic [aets_pkg::RES_W-1:0] sample_in,
	output logic      [CW-1:0]             chan_sel_out,
	output logic                           conv_status_out,
	output logic                           conv_end_irq_out,
	output logic      [CHANS*aets_pkg::RES_W-1:0] results_out
);
	localparam int RW = aets_pkg::RES_W;
	if (CHANS < 2 || CHANS > (1 << CW))
	begin : g_bad_chans
		$error("aets_unit: bad channel count");
	end
	// ****************************************************
	// Trigger synchroniser and edge detect
	// ****************************************************
	logic       sync1_ff, sync2_ff, prev_ff;
	logic [2:0] fill_ff;
	logic       raw_edge, valid_edge;
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff  <= 1'b0;
			fill_ff  <= 3'h0;
		end
		else
		begin
			sync1_ff <= trig_in;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
			fill_ff  <= {fill_ff[1:0], 1'b1};
		end
	end
	// One pulse per edge, so coincident triggers merge
	always_comb
	begin
		case (edge_sel_in)
		aets_pkg::EDGE_RISE: raw_edge = sync2_ff & ~prev_ff;
		aets_pkg::EDGE_FALL: raw_edge = ~sync2_ff & prev_ff;
		aets_pkg::EDGE_BOTH: raw_edge = sync2_ff ^ prev_ff;
		default:             raw_edge = 1'b0;
		endcase
	end
	// No false edge while the chain refills after reset
	assign valid_edge = raw_edge & fill_ff[2];
	// ****************************************************
	// Sequencer
	// ****************************************************
	aets_pkg::aets_state_type state_ff, nxt_state;
	logic [CW-1:0] chan_ff, nxt_chan;
	logic [7:0]    cnt_ff, nxt_cnt;
	logic          irq_ff, nxt_irq;
	logic          status_ff, nxt_status;
	logic [RW-1:0] res_ff [CHANS];
	logic          store;
	logic [7:0]    conv_cyc;
	assign conv_cyc = 8'(aets_pkg::CONV_BASE_CYC
		+ aets_pkg::CONV_STEP_CYC * int'(conv_time_sel_in));
	always_comb
	begin
		nxt_state = state_ff;
		nxt_chan  = chan_ff;
		nxt_cnt   = cnt_ff;
		nxt_irq   = 1'b0;
		store     = 1'b0;
		case (state_ff)
		aets_pkg::AETS_IDLE:
		begin
			if (conv_enable_in && valid_edge && !suspend_in)
			begin
				nxt_state = aets_pkg::AETS_CONV;
				nxt_chan  = scan_mode_in ? chan_first_in : chan_first_in;
				nxt_cnt   = 8'h00;
			end
		end
		aets_pkg::AETS_CONV:
		begin
			// Edges here are ignored
			if (!conv_enable_in)
				nxt_state = aets_pkg::AETS_IDLE;
			else if (!suspend_in)
			begin
				nxt_cnt = cnt_ff + 8'h01;
				if (cnt_ff == conv_cyc - 8'h01)
				begin
					store   = 1'b1;
					nxt_cnt = 8'h00;
					if (!scan_mode_in || chan_ff >= chan_last_in)
					begin
						nxt_irq   = 1'b1;
						nxt_state = aets_pkg::AETS_IDLE;
					end
					else
						nxt_chan = chan_ff + 1'b1;
				end
			end
		end
		default: nxt_state = aets_pkg::AETS_IDLE;
		endcase
		nxt_status = (nxt_state == aets_pkg::AETS_CONV);
	end
	always_ff @(posedge core_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_ff <= aets_pkg::AETS_IDLE;
			chan_ff  <= '0;
			cnt_ff   <= 8'h00;
			irq_ff   <= 1'b0;
			status_ff <= 1'b0;
			for (int i = 0; i < CHANS; i++)
				res_ff[i] <= aets_pkg::RESULT_RST;
		end
		else
		begin
			state_ff <= nxt_state;
			chan_ff  <= nxt_chan;
			cnt_ff   <= nxt_cnt;
			irq_ff   <= nxt_irq;
			status_ff <= nxt_status;
			if (store && int'(chan_ff) < CHANS)
				res_ff[chan_ff] <= sample_in;
		end
	end
	assign chan_sel_out     = chan_ff;
	assign conv_status_out  = status_ff;
	assign conv_end_irq_out = irq_ff;
	for (genvar g = 0; g < CHANS; g++)
	begin : g_res
		assign results_out[g*RW +: RW] = res_ff[g];
	end
	// ****************************************************
	// Checks
	// ****************************************************
	abort_nostore_a: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		(state_ff == aets_pkg::AETS_CONV && !conv_enable_in) |=> !irq_ff
		&& state_ff == aets_pkg::AETS_IDLE && $stable(results_out))
		else $error("abort still ended normally");
	irq_pulse_a: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		irq_ff |=> !irq_ff)
		else $error("end interrupt longer than one cycle");
	scan_step_a: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		(store && scan_mode_in && chan_ff < chan_last_in) |=>
		(chan_ff == $past(chan_ff) + 1'b1) && conv_status_out)
		else $error("scan did not step to next channel");
	standby_hold_a: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		(conv_status_out && conv_enable_in && suspend_in) |=>
		$stable(cnt_ff) && conv_status_out)
		else $error("conversion moved during standby");
	start_edge_a: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		$rose(conv_status_out) |-> $past(valid_edge) && $past(conv_enable_in))
		else $error("conversion started without a valid edge");
	irq_status_a: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		irq_ff |-> !conv_status_out && $past(conv_status_out))
		else $error("end interrupt without status drop");
	ignore_trig_a: assert property (@(posedge core_clk_in)
		disable iff (!arst_n_in)
		(conv_status_out && !store && conv_enable_in) |=>
		$stable(chan_ff))
		else $error("channel moved mid conversion");
endmodule : aets_unit

// ---- aets_pkg.sv ----
// Package of constants for the external trigger conversion sequencer
// Contract
// - Each unit starts only on a valid edge of its own trigger pin
// - Two-bit edge select per unit: rising, falling or both edges
// - Select mode converts one channel per trigger into its result slot
// - Select mode pulses end interrupt after each conversion, clears status
// - Select mode never repeats without a new valid edge
// - Scan mode converts start through end channel, each into its slot
// - Scan mode pulses end interrupt only after last channel, clears status
// - Finished scan restarts from start channel on next valid edge
// - Enable cleared mid-conversion aborts it without storing a result
// - Triggers during a conversion are ignored, never queued
// - Simultaneous triggers count as one trigger event
// - Trigger at conversion end still gives interrupt and stored result
// - HALT suspends conversion; registers kept; reset clears results
// - IDLE or STOP halts conversion; registers kept; reset clears results
// - Forced scan suspension may still finish range and interrupt
package aets_pkg;
	// ****************************************************
	// Edge select codes
	// ****************************************************
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// ****************************************************
	// Channel counts and reset values
	// ****************************************************
	localparam int CHANS_UNIT0 = 6;
	localparam int CHANS_UNIT1 = 8;
	localparam int RES_W       = 10;
	localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
	// ****************************************************
	// Conversion time: base cycles plus step per select code
	// ****************************************************
	localparam int CONV_BASE_CYC = 16;
	localparam int CONV_STEP_CYC = 8;
	typedef enum logic [1:0] {AETS_IDLE, AETS_CONV, AETS_DONE} aets_state_type;
endpackage : aets_pkg

// ---- aets_top.sv ----
// Top of the two-unit external trigger conversion sequencer
`timescale 1ns/1ns
module aets_top (
	input  wire logic        core_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        ext_trigger_pin_unit0_in,
	input  wire logic        ext_trigger_pin_unit1_in,
	input  wire logic        edge_sel_hi_unit0_in,
	input  wire logic        edge_sel_lo_unit0_in,
	input  wire logic        edge_sel_hi_unit1_in,
	input  wire logic        edge_sel_lo_unit1_in,
	input  wire logic        conv_enable_unit0_in,
	input  wire logic        conv_enable_unit1_in,
	input  wire logic        scan_mode_unit0_in,
	input  wire logic        scan_mode_unit1_in,
	input  wire logic [2:0]  chan_first_unit0_in,
	input  wire logic [2:0]  chan_last_unit0_in,
	input  wire logic [2:0]  chan_first_unit1_in,
	input  wire logic [2:0]  chan_last_unit1_in,
	input  wire logic [2:0]  conv_time_sel_unit0_in,
	input  wire logic [2:0]  conv_time_sel_unit1_in,
	input  wire logic        standby_in,
	input  wire logic [9:0]  sample_unit0_in,
	input  wire logic [9:0]  sample_unit1_in,
	output logic      [2:0]  chan_sel_unit0_out,
	output logic      [2:0]  chan_sel_unit1_out,
	output logic             conv_status_unit0_out,
	output logic             conv_status_unit1_out,
	output logic             conv_end_irq_unit0_out,
	output logic             conv_end_irq_unit1_out,
	output logic      [59:0] result_reg_unit0_out,
	output logic      [79:0] result_reg_unit1_out
);
	// ****************************************************
	// Converter units
	// ****************************************************
	aets_unit #(.CHANS(aets_pkg::CHANS_UNIT0), .CW(3)) u_unit0 (
		.core_clk_in      (core_clk_in),
		.arst_n_in        (arst_n_in),
		.trig_in          (ext_trigger_pin_unit0_in),
		.edge_sel_in      ({edge_sel_hi_unit0_in, edge_sel_lo_unit0_in}),
		.conv_enable_in   (conv_enable_unit0_in),
		.scan_mode_in     (scan_mode_unit0_in),
		.chan_first_in    (chan_first_unit0_in),
		.chan_last_in     (chan_last_unit0_in),
		.conv_time_sel_in (conv_time_sel_unit0_in),
		.suspend_in       (standby_in),
		.sample_in        (sample_unit0_in),
		.chan_sel_out     (chan_sel_unit0_out),
		.conv_status_out  (conv_status_unit0_out),
		.conv_end_irq_out (conv_end_irq_unit0_out),
		.results_out      (result_reg_unit0_out)
	);
	aets_unit #(.CHANS(aets_pkg::CHANS_UNIT1), .CW(3)) u_unit1 (
		.core_clk_in      (core_clk_in),
		.arst_n_in        (arst_n_in),
		.trig_in          (ext_trigger_pin_unit1_in),
		.edge_sel_in      ({edge_sel_hi_unit1_in, edge_sel_lo_unit1_in}),
		.conv_enable_in   (conv_enable_unit1_in),
		.scan_mode_in     (scan_mode_unit1_in),
		.chan_first_in    (chan_first_unit1_in),
		.chan_last_in     (chan_last_unit1_in),
		.conv_time_sel_in (conv_time_sel_unit1_in),
		.suspend_in       (standby_in),
		.sample_in        (sample_unit1_in),
		.chan_sel_out     (chan_sel_unit1_out),
		.conv_status_out  (conv_status_unit1_out),
		.conv_end_irq_out (conv_end_irq_unit1_out),
		.results_out      (result_reg_unit1_out)
	);
endmodule : aets_top

// ---- aets_src.sv ----
// Partner model: trigger source and analog front end of both units
`timescale 1ns/1ns
module aets_src (
	input  wire logic       core_clk_in,
	input  wire logic [1:0] lvl_in,
	input  wire logic [9:0] base_in,
	input  wire logic [2:0] chan_sel_unit0_in,
	input  wire logic [2:0] chan_sel_unit1_in,
	output logic      [1:0] pin_out,
	output logic      [9:0] sample_unit0_out,
	output logic      [9:0] sample_unit1_out
);
	// ****
	// Trigger pins follow the requested level one edge later
	// ****
	// Only pin triggers; no timer interrupt source to mask
	initial pin_out = 2'h0;
	always @(posedge core_clk_in)
		pin_out <= lvl_in;
	// ****
	// Analog level depends on the channel being converted
	// ****
	assign sample_unit0_out = base_in + {7'h00, chan_sel_unit0_in};
	assign sample_unit1_out = base_in + 10'h080 + {7'h00, chan_sel_unit1_in};
endmodule : aets_src

// ---- aets_top_tb.sv ----
// Self-checking testbench of the two-unit trigger sequencer
`timescale 1ns/1ns
module aets_top_tb;
	typedef struct packed {
		logic u; logic [1:0] es; logic lv; logic sc;
		logic [2:0] f; logic [2:0] l; logic fire;
	} aets_row_type;
	localparam aets_row_type ROWS [10] = '{
		'{1'b0,2'h0,1'b0,1'b0,3'h2,3'h2,1'b1},
		'{1'b0,2'h1,1'b1,1'b0,3'h5,3'h5,1'b1},
		'{1'b0,2'h3,1'b0,1'b1,3'h0,3'h5,1'b1},
		'{1'b0,2'h3,1'b1,1'b1,3'h1,3'h3,1'b1},
		'{1'b0,2'h1,1'b0,1'b0,3'h0,3'h0,1'b0},
		'{1'b0,2'h0,1'b1,1'b0,3'h0,3'h0,1'b0},
		'{1'b0,2'h2,1'b1,1'b0,3'h0,3'h0,1'b0},
		'{1'b1,2'h1,1'b1,1'b1,3'h0,3'h7,1'b1},
		'{1'b1,2'h0,1'b0,1'b0,3'h7,3'h7,1'b1},
		'{1'b1,2'h3,1'b1,1'b0,3'h0,3'h0,1'b1}};
	logic        clk, rst_n, stby;
	logic [1:0]  lvl, en, scm, st, irq, pin, es0, es1;
	logic [2:0]  f0, l0, f1, l1, ch0, ch1, ts0, ts1;
	logic [9:0]  base, s0, s1;
	logic [59:0] res0, r0;
	logic [79:0] res1, r1;
	int          mismatches, n_tests, cyc, nirq, nst, cu, ncyc;
	aets_src aets_src_inst (.core_clk_in(clk), .lvl_in(lvl), .base_in(base),
		.chan_sel_unit0_in(ch0), .chan_sel_unit1_in(ch1), .pin_out(pin),
		.sample_unit0_out(s0), .sample_unit1_out(s1));
	aets_top aets_top_inst (.core_clk_in(clk), .arst_n_in(rst_n),
		.ext_trigger_pin_unit0_in(pin[0]), .ext_trigger_pin_unit1_in(pin[1]),
		.edge_sel_hi_unit0_in(es0[1]), .edge_sel_lo_unit0_in(es0[0]),
		.edge_sel_hi_unit1_in(es1[1]), .edge_sel_lo_unit1_in(es1[0]),
		.conv_enable_unit0_in(en[0]), .conv_enable_unit1_in(en[1]),
		.scan_mode_unit0_in(scm[0]), .scan_mode_unit1_in(scm[1]),
		.chan_first_unit0_in(f0), .chan_last_unit0_in(l0),
		.chan_first_unit1_in(f1), .chan_last_unit1_in(l1),
		.conv_time_sel_unit0_in(ts0), .conv_time_sel_unit1_in(ts1),
		.standby_in(stby), .sample_unit0_in(s0), .sample_unit1_in(s1),
		.chan_sel_unit0_out(ch0), .chan_sel_unit1_out(ch1),
		.conv_status_unit0_out(st[0]), .conv_status_unit1_out(st[1]),
		.conv_end_irq_unit0_out(irq[0]), .conv_end_irq_unit1_out(irq[1]),
		.result_reg_unit0_out(res0), .result_reg_unit1_out(res1));
	// ****
	// Clock, timeout and shared tasks
	// ****
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial cyc = 0;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			mismatches++;
			finish_test();
		end
	end
	task step();
		@(posedge clk);
		#1;
	endtask : step
	task chk(string nm, logic [79:0] e, logic [79:0] g);
		n_tests++;
		if (e !== g)
		begin
			mismatches++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task watch(int n);
		nirq = 0;
		nst = 0;
		repeat (n)
		begin
			step();
			if (irq[cu] === 1'b1) nirq++;
			if (st[cu] === 1'b1) nst++;
		end
	endtask : watch
	task arm(aets_row_type r);
		cu = r.u;
		en[cu] = 1'b0;
		lvl[cu] = ~r.lv;
		repeat (8) step();
		if (r.u)
		begin
			es1 = r.es; f1 = r.f; l1 = r.l;
		end
		else
		begin
			es0 = r.es; f0 = r.f; l0 = r.l;
		end
		scm[cu] = r.sc;
		en[cu] = 1'b1;
		step();
		lvl[cu] = r.lv;
	endtask : arm
	task upd(aets_row_type r);
		for (int c = r.f; c <= (r.sc ? r.l : r.f); c++)
			if (r.u)
				r1[c*10 +: 10] = base + 10'h080 + 10'(c);
			else
				r0[c*10 +: 10] = base + 10'(c);
	endtask : upd
	task chk_res();
		chk("result0", 80'(r0), 80'(res0));
		chk("result1", r1, res1);
	endtask : chk_res
	task finish_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// ****
	// Main sequence
	// ****
	initial
	begin
		{rst_n, stby, lvl, en, scm, es0, es1} = '0;
		{f0, l0, f1, l1, base, r0, r1} = '0;
		ts0 = 3'h2;
		ts1 = 3'h0;
		mismatches = 0;
		n_tests = 0;
		repeat (16) step();
		rst_n = 1'b1;
		chk_res();
		for (int i = 0; i < 10; i++)
		begin
			base = {i[3:0], 6'h00};
			arm(ROWS[i]);
			watch(300);
			chk("irq count", 80'(ROWS[i].fire), 80'(nirq));
			chk("busy seen", 80'(ROWS[i].fire), 80'(nst != 0));
			ncyc = (aets_pkg::CONV_BASE_CYC + aets_pkg::CONV_STEP_CYC
				* int'(ROWS[i].u ? ts1 : ts0))
				* (ROWS[i].sc ? int'(ROWS[i].l) - int'(ROWS[i].f) + 1 : 1);
			chk("busy cycles", 80'(ROWS[i].fire ? ncyc : 0), 80'(nst));
			chk("status idle", 80'h0, 80'(st[cu]));
			if (ROWS[i].fire) upd(ROWS[i]);
			chk_res();
		end
		$display("test rows done");
		base = 10'h2c0;
		arm('{1'b0,2'h3,1'b1,1'b0,3'h4,3'h4,1'b1});
		repeat (12) step();
		lvl[0] = 1'b0;
		repeat (4) step();
		lvl[0] = 1'b1;
		watch(300);
		chk("irq count", 80'h1, 80'(nirq));
		upd('{1'b0,2'h3,1'b1,1'b0,3'h4,3'h4,1'b1});
		chk_res();
		$display("test ignore done");
		base = 10'h2e0;
		arm('{1'b0,2'h1,1'b1,1'b0,3'h3,3'h3,1'b1});
		repeat (10) step();
		chk("busy", 80'h1, 80'(st[0]));
		chk_res();
		repeat (3)
		begin
			en[0] = 1'b0;
			step();
		end
		chk("busy", 80'h0, 80'(st[0]));
		watch(100);
		chk("irq count", 80'h0, 80'(nirq));
		chk_res();
		$display("test abort done");
		base = 10'h3c0;
		arm('{1'b0,2'h1,1'b1,1'b0,3'h4,3'h4,1'b1});
		repeat (8) step();
		stby = 1'b1;
		watch(100);
		chk("irq count", 80'h0, 80'(nirq));
		chk("busy", 80'h1, 80'(st[0]));
		stby = 1'b0;
		watch(100);
		chk("irq count", 80'h1, 80'(nirq));
		upd('{1'b0,2'h1,1'b1,1'b0,3'h4,3'h4,1'b1});
		chk_res();
		$display("test standby done");
		rst_n = 1'b0;
		step();
		step();
		{r0, r1} = '0;
		chk_res();
		rst_n = 1'b1;
		cu = 0;
		watch(40);
		chk("busy seen", 80'h0, 80'(nst != 0));
		chk("irq count", 80'h0, 80'(nirq));
		$display("test reset done");
		finish_test();
	end
endmodule : aets_top_tb
